//--- test/qdnv_ctrl_asserts.sv
`default_nettype none
module qdnv_ctrl_asserts #(
   parameter int POR_CYC = 20,
   parameter int STORE_CYC = 50
) (
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Serial and mute pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic mute_all,
   // Status and channel outputs
   input wire logic store_done_flag,
   input wire logic [31:0] dac_code,
   input wire logic [3:0] low_reference_level,
   input wire logic [3:0] out_drive_en,
   input wire logic port_enabled
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BUSY_MAX = STORE_CYC + 250;
   logic [15:0] por_cnt;
   //==========================================
   // Power-on cycle count
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         por_cnt <= 16'h0000;
      end else if (!port_enabled) begin
         por_cnt <= por_cnt + 16'h0001;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   //==========================================
   // Properties
   sequence s_pin_held; mute_all [*6]; endsequence
   sequence s_busy_ends; ##[0:BUSY_MAX] store_done_flag; endsequence
   property p_mute_pin; s_pin_held |-> low_reference_level == 4'hF; endproperty
   property p_por_muted; !port_enabled |-> low_reference_level == 4'hF; endproperty
   property p_por_stable; !port_enabled && !$past(port_enabled) |-> $stable(dac_code);
   endproperty
   property p_por_time; $rose(port_enabled) |-> por_cnt >= POR_CYC; endproperty
   property p_por_bound; !port_enabled |-> por_cnt <= POR_CYC + 20; endproperty
   property p_port_stays; port_enabled |=> port_enabled; endproperty
   property p_oe_cs_high; cs_n && $past(cs_n) |-> !sdo_oe; endproperty
   property p_oe_start; $rose(sdo_oe) |-> !cs_n && !$past(cs_n, 8); endproperty
   property p_oe_por; !port_enabled |-> !sdo_oe; endproperty
   property p_read_ready; sdo_oe |-> store_done_flag; endproperty
   property p_store_ends; $fell(store_done_flag) |-> s_busy_ends; endproperty
   property p_drv_after_por; $changed(out_drive_en) |-> port_enabled; endproperty
   a_mute_pin: assert property (p_mute_pin) else $error("mute pin ignored");
   a_por_muted: assert property (p_por_muted) else $error("unmuted in power-on");
   a_por_stable: assert property (p_por_stable) else $error("code moved in power-on");
   a_por_time: assert property (p_por_time) else $error("power-on too short");
   a_por_bound: assert property (p_por_bound) else $error("power-on too long");
   a_port_stays: assert property (p_port_stays) else $error("port dropped");
   a_oe_cs_high: assert property (p_oe_cs_high) else $error("sdo driven");
   a_oe_start: assert property (p_oe_start) else $error("sdo driven early");
   a_oe_por: assert property (p_oe_por) else $error("sdo in power-on");
   a_read_ready: assert property (p_read_ready) else $error("busy during read");
   a_store_ends: assert property (p_store_ends) else $error("store never ends");
   a_drv_after_por: assert property (p_drv_after_por) else $error("early shutdown");
endmodule : qdnv_ctrl_asserts

bind qdnv_ctrl qdnv_ctrl_asserts #(.POR_CYC(POR_CYC), .STORE_CYC(STORE_CYC))
   i_qdnv_ctrl_asserts (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
   .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .mute_all(mute_all),
   .store_done_flag(store_done_flag), .dac_code(dac_code),
   .low_reference_level(low_reference_level), .out_drive_en(out_drive_en),
   .port_enabled(port_enabled));
`default_nettype wire

//--- test/qdnv_ctrl_tb_top.sv
`default_nettype none
module qdnv_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int POR_T = 400;
   localparam logic [39:0] NV_IMG = 40'h2144332211;
   typedef struct packed {
      logic [13:0] word;
      logic [31:0] dac;
      logic [3:0] lref;
      logic [3:0] drv;
   } qdnv_row_s;
   logic clk_sys, rstn, mute_all, sclk, cs_n, sdi, sdo, sdo_oe, flag, port_en, oe;
   logic [31:0] dac_code;
   logic [3:0] lref, drv;
   logic [7:0] rd;
   qdnv_row_s rows [9];
   int mismatches = 0;
   int compares = 0;
   qdnv_ctrl #(.NV_INIT(NV_IMG), .POR_CYC(POR_T), .STORE_CYC(50)) i_qdnv_ctrl (
      .clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
      .sdo_oe(sdo_oe), .mute_all(mute_all), .store_done_flag(flag), .dac_code(dac_code),
      .low_reference_level(lref), .out_drive_en(drv), .port_enabled(port_en));
   qdnv_host i_qdnv_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   //==========================================
   // Helpers
   function automatic logic [13:0] wd(input logic [1:0] c, input logic [2:0] a,
                                      input logic [7:0] d);
      return {1'b1, c, a, d};
   endfunction : wd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc
   task automatic send(input logic [13:0] w);
      i_qdnv_host.frame(w, rd, oe);
      cyc(12);
   endtask : send
   task automatic outs(input logic [31:0] d, input logic [3:0] l, input logic [3:0] e);
      chk(dac_code, d, "codes");
      chk({28'h0, lref}, {28'h0, l}, "mute");
      chk({28'h0, drv}, {28'h0, e}, "drive");
   endtask : outs
   task automatic rd_nv(input logic [2:0] a, input logic [7:0] exp);
      send(wd(qdnv_pkg::CMD_READ, a, 8'h00));
      chk({24'h0, rd}, {24'h0, exp}, "read byte");
      chk({31'h0, oe}, 32'h1, "sdo driven");
      chk({30'h0, sdo_oe, flag}, 32'h1, "oe off, ready");
   endtask : rd_nv
   task automatic wait_flag;
      for (int i = 0; i < 300 && flag !== 1'b1; i++) cyc(1);
      chk({31'h0, flag}, 32'h1, "store done");
   endtask : wait_flag
   task automatic wait_port;
      for (int i = 0; i < POR_T + 50 && port_en !== 1'b1; i++) cyc(1);
      chk({31'h0, port_en}, 32'h1, "port up");
   endtask : wait_port
   task automatic results;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   initial begin
      #300us;
      mismatches++;
      results();
   end
   //==========================================
   // Main sequence
   initial begin
      rstn = 1'b0;
      mute_all = 1'b0;
      rows[0] = '{wd(qdnv_pkg::CMD_WRITE, 3'h0, 8'h5A), 32'h4433225A, 4'h2, 4'hE};
      rows[1] = '{wd(qdnv_pkg::CMD_WRITE, 3'h3, 8'hFF), 32'hFF33225A, 4'h2, 4'hE};
      rows[2] = '{wd(qdnv_pkg::CMD_WRITE, 3'h4, 8'h00), 32'hFF33225A, 4'h0, 4'hF};
      rows[3] = '{wd(qdnv_pkg::CMD_WRITE, 3'h1, 8'h00), 32'hFF33005A, 4'h0, 4'hF};
      rows[4] = '{wd(qdnv_pkg::CMD_WRITE, 3'h4, 8'h84), 32'hFF33005A, 4'h8, 4'hB};
      rows[5] = '{wd(qdnv_pkg::CMD_LOAD, 3'h1, 8'hA5), 32'hFF33225A, 4'h8, 4'hB};
      rows[6] = '{wd(qdnv_pkg::CMD_LOAD, 3'h4, 8'h00), 32'hFF33225A, 4'h2, 4'hE};
      rows[7] = '{wd(qdnv_pkg::CMD_WRITE, 3'h4, 8'h00), 32'hFF33225A, 4'h0, 4'hF};
      rows[8] = '{wd(qdnv_pkg::CMD_WRITE, 3'h5, 8'hAA), 32'hFF33225A, 4'h0, 4'hF};
      cyc(9);
      outs(32'h0, 4'hF, 4'hF);
      chk({30'h0, flag, port_en}, 32'h2, "reset status");
      @(posedge clk_sys) rstn <= 1'b1;
      wait_port();
      outs(NV_IMG[31:0], 4'h2, 4'hE);
      foreach (rows[i]) begin
         send(rows[i].word);
         outs(rows[i].dac, rows[i].lref, rows[i].drv);
      end
      for (int a = 0; a < 5; a++) rd_nv(a[2:0], NV_IMG[a*8 +: 8]);
      send(wd(qdnv_pkg::CMD_READ, 3'h5, 8'h00));
      chk({31'h0, oe}, 32'h0, "no drive");
      send(wd(qdnv_pkg::CMD_STORE, 3'h0, 8'hC3));
      chk({31'h0, flag}, 32'h0, "busy");
      outs(32'hFF33225A, 4'h0, 4'hF);
      wait_flag();
      rd_nv(3'h0, 8'hC3);
      send(wd(qdnv_pkg::CMD_LOAD, 3'h0, 8'h00));
      outs(32'hFF3322C3, 4'h0, 4'hF);
      rd_nv(3'h0, 8'hC3);
      send(wd(qdnv_pkg::CMD_WRITE, 3'h4, 8'hF0));
      send(wd(qdnv_pkg::CMD_STORE, 3'h1, 8'h99));
      chk({31'h0, flag}, 32'h1, "store refused");
      rd_nv(3'h1, 8'h22);
      send(wd(qdnv_pkg::CMD_WRITE, 3'h4, 8'h00));
      send(wd(qdnv_pkg::CMD_STORE, 3'h1, 8'h99));
      chk({31'h0, flag}, 32'h0, "busy again");
      wait_flag();
      rd_nv(3'h1, 8'h99);
      @(posedge clk_sys) mute_all <= 1'b1;
      cyc(8);
      outs(32'hFF3322C3, 4'hF, 4'hF);
      @(posedge clk_sys) mute_all <= 1'b0;
      cyc(8);
      outs(32'hFF3322C3, 4'h0, 4'hF);
      @(posedge clk_sys) rstn <= 1'b0;
      cyc(10);
      @(posedge clk_sys) rstn <= 1'b1;
      send(wd(qdnv_pkg::CMD_WRITE, 3'h0, 8'h5A));
      chk({31'h0, port_en}, 32'h0, "still in power-on");
      wait_port();
      outs(NV_IMG[31:0], 4'h2, 4'hE);
      results();
   end
endmodule : qdnv_ctrl_tb_top
`default_nettype wire

//--- test/qdnv_host.sv
`default_nettype none
module qdnv_host (
   // Serial pins towards the device
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   // Read-back from the device
   input wire logic sdo,
   input wire logic sdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   //==========================================
   // One word, clock idles low between words
   task automatic frame(input logic [13:0] w, output logic [7:0] rd, output logic oe_seen);
      rd = 8'h00;
      oe_seen = 1'b0;
      cs_n = 1'b0;
      #100;
      for (int i = 13; i >= 0; i--) begin
         sdi = w[i];
         #62.5 sclk = 1'b1;
         #62.5 sclk = 1'b0;
         oe_seen = oe_seen | sdo_oe;
         if (i >= 1 && i <= 8) begin
            rd = {rd[6:0], sdo};
         end
      end
      #62.5 cs_n = 1'b1;
      sdi = ~sdi;
      #200;
   endtask : frame
endmodule : qdnv_host
`default_nettype wire

//--- verilog/qdnv_ctrl.sv
`default_nettype none
module qdnv_ctrl #(
   // Nonvolatile contents loaded at every reset
   parameter logic [qdnv_pkg::IMG_W-1:0] NV_INIT = '0,
   // Power-on load time in clk_sys cycles
   parameter int POR_CYC = qdnv_pkg::POR_CYCLES,
   // Nonvolatile store time in clk_sys cycles
   parameter int STORE_CYC = qdnv_pkg::STORE_CYCLES
) (
   // System clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Serial port pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   // Mute pin, high mutes every channel
   input wire logic mute_all,
   // Store status, high when ready
   output logic store_done_flag,
   // Channel codes, channel 0 in the low byte
   output logic [qdnv_pkg::NUM_CH*qdnv_pkg::DATA_W-1:0] dac_code,
   // Channel drives its low reference
   output logic [qdnv_pkg::NUM_CH-1:0] low_reference_level,
   // Channel output driver enabled
   output logic [qdnv_pkg::NUM_CH-1:0] out_drive_en,
   // Serial port accepting words
   output logic port_enabled
);
   //==========================================================
   // Constants
   localparam int TW = qdnv_pkg::TMR_W;
   localparam int NCH = qdnv_pkg::NUM_CH;
   localparam int DW = qdnv_pkg::DATA_W;
   localparam int SY_W = 4;
   localparam int SY_HDR = 0;
   localparam int SY_WD = 1;
   localparam int SY_CS = 2;
   localparam int SY_MUTE = 3;
   localparam logic [TW-1:0] POR_LAST = TW'(POR_CYC - 1);

   //==========================================================
   // State
   typedef struct packed {
      qdnv_pkg::qdnv_state_e state;
      qdnv_pkg::qdnv_rdph_e rd_ph;
      logic [TW-1:0] por_tmr;
      logic [1:0] por_idx;
      logic [2:0] rd_addr;
      logic ld_pend;
      logic [SY_W-1:0] sy1;
      logic [SY_W-1:0] sy2;
      logic [SY_W-1:0] sy3;
      logic [SY_W-1:0] filt;
      logic [NCH-1:0][DW-1:0] vol_code;
      logic [DW-1:0] vol_ms;
      logic st_pend;
      logic st_busy;
      logic wr_req;
      logic [2:0] wr_addr;
      logic [DW-1:0] wr_data;
      logic port_en;
      logic [NCH-1:0][DW-1:0] code;
      logic [NCH-1:0] lowref;
      logic [NCH-1:0] drv;
      logic ready;
   } qdnv_sys_s;

   localparam qdnv_sys_s SYS_RESET = '{
      state: qdnv_pkg::ST_POR_CH,
      rd_ph: qdnv_pkg::PH_IDLE,
      vol_code: {NCH{qdnv_pkg::CODE_RESET}},
      vol_ms: qdnv_pkg::MS_RESET,
      lowref: '1,
      drv: '1,
      ready: 1'b1,
      default: '0
   };

   qdnv_sys_s st;
   qdnv_sys_s next_st;

   //==========================================================
   // Submodules
   qdnv_nv_if nv();
   qdnv_link_if lk();

   qdnv_nvmem #(
      .NV_INIT(NV_INIT),
      .STORE_CYC(STORE_CYC)
   ) u_nvmem (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .nv(nv)
   );

   qdnv_link u_link (
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .lk(lk)
   );

   assign nv.wr_req = st.wr_req;
   assign nv.wr_addr = st.wr_addr;
   assign nv.wr_data = st.wr_data;
   assign nv.rd_addr = st.rd_addr;
   assign lk.port_en = st.port_en;
   assign lk.image = nv.image;

   //==========================================================
   // Decoded inputs
   logic [SY_W-1:0] agree;
   logic [SY_W-1:0] filt_now;
   logic hdr_ev;
   logic wd_ev;
   logic cs_hi;
   logic mute_eff;
   logic [NCH-1:0] ms_mute;
   logic [NCH-1:0] ms_off;
   logic all_quiet;
   logic running;
   logic [1:0] hcmd;
   logic [2:0] haddr;
   logic [1:0] wcmd;
   logic [2:0] waddr;
   logic [DW-1:0] wdata;
   logic [NCH-1:0] out_mute;
   logic out_por;

   //==========================================================
   // Next state
   always_comb begin
      agree = ~(st.sy2 ^ st.sy3);
      filt_now = (agree & st.sy3) | (~agree & st.filt);
      hdr_ev = agree[SY_HDR] & st.sy3[SY_HDR] & ~st.filt[SY_HDR];
      wd_ev = agree[SY_WD] & st.sy3[SY_WD] & ~st.filt[SY_WD];
      cs_hi = filt_now[SY_CS];
      mute_eff = filt_now[SY_MUTE];
      ms_mute = st.vol_ms[qdnv_pkg::MS_MUTE_LSB +: NCH];
      ms_off = st.vol_ms[qdnv_pkg::MS_OFF_LSB +: NCH];
      all_quiet = &(ms_mute | ms_off | {NCH{mute_eff}});
      running = (st.state == qdnv_pkg::ST_RUN);
      hcmd = lk.hdr[4:3];
      haddr = lk.hdr[2:0];
      wcmd = lk.word[12:11];
      waddr = lk.word[10:8];
      wdata = lk.word[DW-1:0];
      out_mute = '0;
      out_por = 1'b0;

      next_st = st;
      next_st.wr_req = 1'b0;

      // Three-stage crossing, level accepted once stages two and three agree
      next_st.sy1 = {mute_all, cs_n, lk.wd_vld, lk.hdr_vld};
      next_st.sy2 = st.sy1;
      next_st.sy3 = st.sy2;
      next_st.filt = filt_now;

      if (!running && st.por_tmr != POR_LAST) begin
         next_st.por_tmr = st.por_tmr + 1'b1;
      end

      case (st.state)
         qdnv_pkg::ST_POR_CH: begin
            // Channel registers load first
            case (st.rd_ph)
               qdnv_pkg::PH_IDLE: begin
                  next_st.rd_addr = {1'b0, st.por_idx};
                  next_st.rd_ph = qdnv_pkg::PH_WAIT;
               end
               qdnv_pkg::PH_WAIT: begin
                  next_st.rd_ph = qdnv_pkg::PH_TAKE;
               end
               qdnv_pkg::PH_TAKE: begin
                  next_st.vol_code[st.por_idx] = nv.rd_data;
                  next_st.rd_ph = qdnv_pkg::PH_IDLE;
                  next_st.por_idx = st.por_idx + 2'h1;
                  if (st.por_idx == 2'h3) begin
                     next_st.state = qdnv_pkg::ST_POR_WAIT;
                  end
               end
               default: begin
                  next_st.rd_ph = qdnv_pkg::PH_IDLE;
               end
            endcase
         end
         qdnv_pkg::ST_POR_WAIT: begin
            if (st.por_tmr == POR_LAST) begin
               next_st.state = qdnv_pkg::ST_POR_MS;
            end
         end
         qdnv_pkg::ST_POR_MS: begin
            // Mute/shutdown register loads last
            case (st.rd_ph)
               qdnv_pkg::PH_IDLE: begin
                  next_st.rd_addr = qdnv_pkg::ADDR_MS;
                  next_st.rd_ph = qdnv_pkg::PH_WAIT;
               end
               qdnv_pkg::PH_WAIT: begin
                  next_st.rd_ph = qdnv_pkg::PH_TAKE;
               end
               qdnv_pkg::PH_TAKE: begin
                  next_st.vol_ms = nv.rd_data;
                  next_st.rd_ph = qdnv_pkg::PH_IDLE;
                  next_st.state = qdnv_pkg::ST_RUN;
               end
               default: begin
                  next_st.rd_ph = qdnv_pkg::PH_IDLE;
               end
            endcase
         end
         qdnv_pkg::ST_RUN: begin
            // Load in progress: fetch then copy into the volatile side
            if (st.ld_pend) begin
               if (st.rd_ph == qdnv_pkg::PH_WAIT) begin
                  next_st.rd_ph = qdnv_pkg::PH_TAKE;
               end else begin
                  if (st.rd_addr == qdnv_pkg::ADDR_MS) begin
                     next_st.vol_ms = nv.rd_data;
                  end else begin
                     next_st.vol_code[st.rd_addr[1:0]] = nv.rd_data;
                  end
                  next_st.rd_ph = qdnv_pkg::PH_IDLE;
                  next_st.ld_pend = 1'b0;
               end
            end

            // Header complete: store and load act here
            if (hdr_ev && qdnv_pkg::addr_ok(haddr)) begin
               if (hcmd == qdnv_pkg::CMD_STORE && !all_quiet
                   && !st.st_busy && !nv.busy) begin
                  next_st.st_pend = 1'b1;
                  next_st.st_busy = 1'b1;
               end
               if (hcmd == qdnv_pkg::CMD_LOAD && !st.ld_pend) begin
                  next_st.ld_pend = 1'b1;
                  next_st.rd_addr = haddr;
                  next_st.rd_ph = qdnv_pkg::PH_WAIT;
               end
            end

            // Word complete: store issues, register write updates
            if (wd_ev) begin
               if (st.st_pend && wcmd == qdnv_pkg::CMD_STORE) begin
                  next_st.st_pend = 1'b0;
                  next_st.wr_req = 1'b1;
                  next_st.wr_addr = waddr;
                  next_st.wr_data = wdata;
               end
               if (wcmd == qdnv_pkg::CMD_WRITE && qdnv_pkg::addr_ok(waddr)) begin
                  if (waddr == qdnv_pkg::ADDR_MS) begin
                     next_st.vol_ms = wdata;
                  end else begin
                     next_st.vol_code[waddr[1:0]] = wdata;
                  end
               end
            end else if (cs_hi && st.st_pend) begin
               // Frame cut short after the header: drop the store
               next_st.st_pend = 1'b0;
               next_st.st_busy = 1'b0;
            end

            // Ready again once the nonvolatile write has finished
            if (st.st_busy && !st.st_pend && !st.wr_req && !nv.busy) begin
               next_st.st_busy = 1'b0;
            end
         end
         default: begin
            next_st.state = qdnv_pkg::ST_POR_CH;
         end
      endcase

      //=======================================================
      // Registered outputs
      out_por = (next_st.state != qdnv_pkg::ST_RUN);
      out_mute = next_st.vol_ms[qdnv_pkg::MS_MUTE_LSB +: NCH] | {NCH{mute_eff}};
      // Codes held until the power-on load ends, then all apply at once
      next_st.code = out_por ? st.code : next_st.vol_code;
      next_st.lowref = out_por ? '1 : out_mute;
      next_st.drv = out_por ? '1 : ~next_st.vol_ms[qdnv_pkg::MS_OFF_LSB +: NCH];
      next_st.ready = ~next_st.st_busy;
      next_st.port_en = ~out_por;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st <= SYS_RESET;
      end else begin
         st <= next_st;
      end
   end

   //==========================================================
   // Outputs
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign dac_code[i*DW +: DW] = st.code[i];
   end
   assign low_reference_level = st.lowref;
   assign out_drive_en = st.drv;
   assign store_done_flag = st.ready;
   assign port_enabled = st.port_en;
   assign sdo = lk.sdo;
   assign sdo_oe = lk.sdo_oe;
endmodule : qdnv_ctrl
`default_nettype wire

//--- verilog/qdnv_ifs.sv
`default_nettype none
interface qdnv_nv_if;
   logic wr_req;
   logic [2:0] wr_addr;
   logic [qdnv_pkg::DATA_W-1:0] wr_data;
   logic [2:0] rd_addr;
   logic [qdnv_pkg::DATA_W-1:0] rd_data;
   logic busy;
   logic [qdnv_pkg::IMG_W-1:0] image;
   modport ctrl(output wr_req, wr_addr, wr_data, rd_addr, input rd_data, busy, image);
   modport mem(input wr_req, wr_addr, wr_data, rd_addr, output rd_data, busy, image);
endinterface : qdnv_nv_if

interface qdnv_link_if;
   logic port_en;
   logic [qdnv_pkg::IMG_W-1:0] image;
   logic hdr_vld;
   logic [qdnv_pkg::HDR_W-1:0] hdr;
   logic wd_vld;
   logic [qdnv_pkg::WORD_W-1:0] word;
   logic sdo;
   logic sdo_oe;
   modport ctrl(output port_en, image, input hdr_vld, hdr, wd_vld, word, sdo, sdo_oe);
   modport link(input port_en, image, output hdr_vld, hdr, wd_vld, word, sdo, sdo_oe);
endinterface : qdnv_link_if
`default_nettype wire

//--- verilog/qdnv_link.sv
`default_nettype none
module qdnv_link (
   // Serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   // Controller side
   qdnv_link_if.link lk
);
   typedef struct packed {
      logic [3:0] cnt;
      logic hdr_vld;
      logic wd_vld;
      logic [7:0] rd_sh;
      logic sdo;
      logic sdo_oe;
   } qdnv_lkf_s;
   typedef struct packed {
      logic [qdnv_pkg::WORD_W-1:0] sh;
      logic [qdnv_pkg::HDR_W-1:0] hdr;
   } qdnv_lkd_s;
   qdnv_lkf_s f;
   qdnv_lkf_s next_f;
   qdnv_lkd_s d;
   qdnv_lkd_s next_d;
   logic frame_rst;
   logic [qdnv_pkg::WORD_W-1:0] shifted;
   logic [7:0] rd_byte;
   // Frame ends with select high; port held off during power-on
   assign frame_rst = cs_n | ~lk.port_en;
   assign shifted = {d.sh[qdnv_pkg::WORD_W-2:0], sdi};
   assign rd_byte = qdnv_pkg::nv_byte(lk.image, shifted[2:0]);
   always_comb begin
      next_f = f;
      next_d = d;
      if (f.cnt == qdnv_pkg::CNT_IDLE) begin
         next_f.cnt = {3'h0, sdi};
      end else if (f.cnt != qdnv_pkg::CNT_DONE) begin
         next_d.sh = shifted;
         next_f.cnt = f.cnt + 4'h1;
         if (f.cnt != qdnv_pkg::CNT_D0) begin
            next_f.rd_sh = {f.rd_sh[6:0], 1'b0};
            next_f.sdo = f.rd_sh[6];
         end
         if (f.cnt == qdnv_pkg::CNT_A0) begin
            next_d.hdr = shifted[qdnv_pkg::HDR_W-1:0];
            next_f.hdr_vld = 1'b1;
            if (shifted[4:3] == qdnv_pkg::CMD_READ && qdnv_pkg::addr_ok(shifted[2:0])) begin
               next_f.rd_sh = rd_byte;
               next_f.sdo = rd_byte[7];
               next_f.sdo_oe = 1'b1;
            end
         end
         next_f.wd_vld = f.wd_vld | (f.cnt == qdnv_pkg::CNT_D0);
      end
   end
   always_ff @(posedge sclk or posedge frame_rst) begin
      if (frame_rst) begin
         f <= '0;
      end else begin
         f <= next_f;
      end
   end
   // Word data held past the frame for the system side
   always_ff @(posedge sclk) begin
      d <= next_d;
   end
   assign lk.hdr_vld = f.hdr_vld;
   assign lk.wd_vld = f.wd_vld;
   assign lk.hdr = d.hdr;
   assign lk.word = d.sh;
   assign lk.sdo = f.sdo;
   assign lk.sdo_oe = f.sdo_oe;
endmodule : qdnv_link
`default_nettype wire

//--- verilog/qdnv_nvmem.sv
`default_nettype none
module qdnv_nvmem #(
   parameter logic [qdnv_pkg::IMG_W-1:0] NV_INIT = '0,
   parameter int STORE_CYC = qdnv_pkg::STORE_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Controller side
   qdnv_nv_if.mem nv
);
   localparam int TW = qdnv_pkg::TMR_W;
   localparam logic [TW-1:0] STORE_LAST = TW'(STORE_CYC - 1);
   typedef struct packed {
      logic [qdnv_pkg::IMG_W-1:0] mem;
      logic [qdnv_pkg::DATA_W-1:0] rd_data;
      logic busy;
      logic [TW-1:0] tmr;
      logic [2:0] wa;
      logic [qdnv_pkg::DATA_W-1:0] wd;
   } qdnv_nvm_s;
   qdnv_nvm_s st;
   qdnv_nvm_s next_st;
   always_comb begin
      next_st = st;
      next_st.rd_data = qdnv_pkg::nv_byte(st.mem, nv.rd_addr);
      if (!st.busy) begin
         if (nv.wr_req) begin
            next_st.busy = 1'b1;
            next_st.tmr = STORE_LAST;
            next_st.wa = nv.wr_addr;
            next_st.wd = nv.wr_data;
         end
      end else if (st.tmr == '0) begin
         next_st.busy = 1'b0;
         next_st.mem[st.wa*qdnv_pkg::DATA_W +: qdnv_pkg::DATA_W] = st.wd;
      end else begin
         next_st.tmr = st.tmr - 1'b1;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st <= '{mem: NV_INIT, default: '0};
      end else begin
         st <= next_st;
      end
   end
   assign nv.rd_data = st.rd_data;
   assign nv.busy = st.busy;
   assign nv.image = st.mem;
endmodule : qdnv_nvmem
`default_nettype wire

//--- verilog/qdnv_pkg.sv
//==========================================================
`default_nettype none
package qdnv_pkg;
   localparam int NUM_CH = 4;
   localparam int DATA_W = 8;
   localparam int NV_WORDS = 5;
   localparam int IMG_W = NV_WORDS * DATA_W;
   localparam int WORD_W = 13;
   localparam int HDR_W = 5;
   localparam int TMR_W = 21;
   localparam logic [3:0] CNT_IDLE = 4'h0;
   localparam logic [3:0] CNT_A0 = 4'h5;
   localparam logic [3:0] CNT_D0 = 4'hD;
   localparam logic [3:0] CNT_DONE = 4'hE;
   localparam logic [1:0] CMD_STORE = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_READ = 2'h2;
   localparam logic [1:0] CMD_LOAD = 2'h3;
   localparam logic [2:0] ADDR_MS = 3'h4;
   localparam int MS_MUTE_LSB = 4;
   localparam int MS_OFF_LSB = 0;
   localparam logic [7:0] CODE_RESET = 8'h00;
   localparam logic [7:0] MS_RESET = 8'h00;
   localparam int CLK_MHZ = 100;
   localparam int POR_TIME_US = 80;
   localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
   localparam int STORE_TIME_MS = 13;
   localparam int STORE_CYCLES = STORE_TIME_MS * 1000 * CLK_MHZ;
   typedef enum logic [1:0] {ST_POR_CH, ST_POR_WAIT, ST_POR_MS, ST_RUN} qdnv_state_e;
   typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_TAKE} qdnv_rdph_e;
   function automatic logic addr_ok(input logic [2:0] a);
      return a <= ADDR_MS;
   endfunction : addr_ok
   function automatic logic [DATA_W-1:0] nv_byte(input logic [IMG_W-1:0] img,
                                                 input logic [2:0] a);
      return addr_ok(a) ? img[a*DATA_W +: DATA_W] : '0;
   endfunction : nv_byte
endpackage : qdnv_pkg
`default_nettype wire
